// [src/tcmfc_defines.svh]
// Register offsets, field positions, reset values for the timer channel block
`ifndef TCMFC_DEFINES_SVH
`define TCMFC_DEFINES_SVH
`define TCMFC_NUM_CH 6
`define TCMFC_OFS_STAT_BASE 8'h00
`define TCMFC_OFS_TSC 8'h18
`define TCMFC_OFS_INT_STAT 8'h1C
`define TCMFC_OFS_CMP_BASE 8'h20
`define TCMFC_OFS_INT_MASK 8'h38
`define TCMFC_BIT_FLAG 7
`define TCMFC_BIT_IE 6
`define TCMFC_BIT_BMS 5
`define TCMFC_BIT_MODE 4
`define TCMFC_BIT_ELS_HI 3
`define TCMFC_BIT_ELS_LO 2
`define TCMFC_BIT_HALT 5
`define TCMFC_BIT_CRST 4
`define TCMFC_RST_HALT 1'h1
`define TCMFC_RST_STAT 8'h00
`define TCMFC_RESP_OKAY 2'h0
`define TCMFC_RESP_SLVERR 2'h2
`endif

// [src/tcmfc_pkg.sv]
// Types shared by the timer channel block
package tcmfc_pkg;
    typedef enum logic [1:0] {
        TCMFC_ELS_NONE = 2'b00,
        TCMFC_ELS_RISE = 2'b01,
        TCMFC_ELS_FALL = 2'b10,
        TCMFC_ELS_BOTH = 2'b11
    } tcmfc_els_e;
    typedef logic [7:0] tcmfc_addr_t;
endpackage : tcmfc_pkg

// [src/tcmfc_top.sv]
// Six-channel timer mode and flag control with an AXI4-Lite register slave
`include "tcmfc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tcmfc_top import tcmfc_pkg::*; (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [15:0] COUNT,
    input wire logic [5:0] CHANNEL_PIN_IN,
    output logic [5:0] CHANNEL_PIN_OUT,
    output logic [5:0] CHANNEL_PIN_OE_N,
    output logic [5:0] CHANNEL_IRQ,
    output logic COUNTER_HALT,
    output logic COUNTER_RESET,
    output logic IRQ
);
    localparam int NCH = `TCMFC_NUM_CH;

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // Channel index of a per-channel word at base, or 7 when outside
    function automatic logic [2:0] ch_index(input tcmfc_addr_t a, input tcmfc_addr_t base);
        tcmfc_addr_t d;
        d = a - base;
        if (a >= base && d[1:0] == 2'h0 && d[7:2] < 6'(NCH))
            ch_index = d[4:2];
        else
            ch_index = 3'h7;
    endfunction : ch_index

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [5:0] flag_ff, ie_ff, bms_ff, mode_ff, armed_ff, lvl_ff;
    logic [1:0] els_ff [NCH];
    logic [15:0] cmp_ff [NCH];
    logic [5:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, match_ff;
    logic [5:0] int_stat_ff, int_mask_ff;
    logic [5:0] off, out_mode, cap_ev, cmp_ev, ev, match_now;
    logic aw_held_ff, w_held_ff;
    tcmfc_addr_t awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic do_wr, ar_fire;
    logic [2:0] wr_st, wr_cmp, rd_st, rd_cmp;

    // ****************************************************************
    // Channel event detection
    // ****************************************************************
    // Odd partner is dead while its even neighbour runs buffered
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            off[i] = (i % 2 == 1) && bms_ff[i - (i % 2)];
            out_mode[i] = bms_ff[i] | (mode_ff[i] & (els_ff[i] != TCMFC_ELS_NONE));
            unique case (tcmfc_els_e'(els_ff[i]))
                TCMFC_ELS_RISE: cap_ev[i] = pin_s2_ff[i] & ~pin_s3_ff[i];
                TCMFC_ELS_FALL: cap_ev[i] = ~pin_s2_ff[i] & pin_s3_ff[i];
                TCMFC_ELS_BOTH: cap_ev[i] = pin_s2_ff[i] ^ pin_s3_ff[i];
                TCMFC_ELS_NONE: cap_ev[i] = 1'b0;
            endcase
            cap_ev[i] = cap_ev[i] & ~out_mode[i] & ~off[i];
            match_now[i] = (COUNT == cmp_ff[i]);
            // Only the first cycle of a match counts, a halted counter would refire
            cmp_ev[i] = match_now[i] & ~match_ff[i] & out_mode[i] & ~off[i];
            ev[i] = cap_ev[i] | cmp_ev[i];
        end
    end

    // Pin synchroniser; stage one feeds stage two only
    always_ff @(posedge CLK) begin
        if (RST) begin
            pin_s1_ff <= 6'h00;
            pin_s2_ff <= 6'h00;
            pin_s3_ff <= 6'h00;
            match_ff <= 6'h00;
        end else begin
            pin_s1_ff <= CHANNEL_PIN_IN;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            match_ff <= match_now;
        end
    end

    // ****************************************************************
    // AXI4-Lite write path
    // ****************************************************************
    assign do_wr = aw_held_ff & w_held_ff & ~S_AXI_BVALID;
    assign wr_st = ch_index(awaddr_ff, `TCMFC_OFS_STAT_BASE);
    assign wr_cmp = ch_index(awaddr_ff, `TCMFC_OFS_CMP_BASE);

    // Address and data are taken in either order, one write at a time
    always_ff @(posedge CLK) begin
        if (RST) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `TCMFC_RESP_OKAY;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held_ff <= 1'b1;
                wdata_ff <= S_AXI_WDATA;
                wstrb_ff <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            if (do_wr) begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                if (wr_st != 3'h7 || wr_cmp != 3'h7 || awaddr_ff == `TCMFC_OFS_TSC ||
                    awaddr_ff == `TCMFC_OFS_INT_STAT || awaddr_ff == `TCMFC_OFS_INT_MASK)
                    S_AXI_BRESP <= `TCMFC_RESP_OKAY;
                else
                    S_AXI_BRESP <= `TCMFC_RESP_SLVERR;
            end
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Channel control fields
    // ****************************************************************
    // Partner channel ignores status writes while disabled; odd channels have no buffered bit
    always_ff @(posedge CLK) begin
        if (RST) begin
            ie_ff <= 6'h00;
            bms_ff <= 6'h00;
            mode_ff <= 6'h00;
            for (int i = 0; i < NCH; i++) begin
                els_ff[i] <= 2'h0;
                cmp_ff[i] <= 16'h0000;
            end
        end else if (do_wr) begin
            if (wr_st != 3'h7 && !off[wr_st] && wstrb_ff[0]) begin
                ie_ff[wr_st] <= wdata_ff[`TCMFC_BIT_IE];
                bms_ff[wr_st] <= wdata_ff[`TCMFC_BIT_BMS] & ~wr_st[0];
                mode_ff[wr_st] <= wdata_ff[`TCMFC_BIT_MODE];
                els_ff[wr_st] <= wdata_ff[`TCMFC_BIT_ELS_HI:`TCMFC_BIT_ELS_LO];
            end
            if (wr_cmp != 3'h7) begin
                if (wstrb_ff[0])
                    cmp_ff[wr_cmp][7:0] <= wdata_ff[7:0];
                if (wstrb_ff[1])
                    cmp_ff[wr_cmp][15:8] <= wdata_ff[15:8];
            end
        end
    end

    // ****************************************************************
    // Event flags and clearing sequence
    // ****************************************************************
    // Events win over the zero write and disarm any pending clear
    always_ff @(posedge CLK) begin
        if (RST) begin
            flag_ff <= 6'h00;
            armed_ff <= 6'h00;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (ev[i]) begin
                    flag_ff[i] <= 1'b1;
                    armed_ff[i] <= 1'b0;
                end else begin
                    if (ar_fire && rd_st == 3'(i) && flag_ff[i] && !off[i])
                        armed_ff[i] <= 1'b1;
                    // A one written here is ignored
                    if (do_wr && wr_st == 3'(i) && wstrb_ff[0] && !off[i] &&
                        !wdata_ff[`TCMFC_BIT_FLAG]) begin
                        if (armed_ff[i])
                            flag_ff[i] <= 1'b0;
                        armed_ff[i] <= 1'b0;
                    end
                end
            end
        end
    end

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    // Edge select 00 presets the level; compare matches then act on it
    always_ff @(posedge CLK) begin
        if (RST) begin
            lvl_ff <= 6'h3F; // mode 0 after reset means high
            CHANNEL_PIN_OUT <= 6'h3F;
            CHANNEL_PIN_OE_N <= 6'h3F;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (els_ff[i] == TCMFC_ELS_NONE && !bms_ff[i])
                    lvl_ff[i] <= ~mode_ff[i];
                else if (cmp_ev[i]) begin
                    unique case (tcmfc_els_e'(els_ff[i]))
                        TCMFC_ELS_RISE: lvl_ff[i] <= ~lvl_ff[i];
                        TCMFC_ELS_FALL: lvl_ff[i] <= 1'b0;
                        TCMFC_ELS_BOTH: lvl_ff[i] <= 1'b1;
                        TCMFC_ELS_NONE: lvl_ff[i] <= lvl_ff[i];
                    endcase
                end
                CHANNEL_PIN_OE_N[i] <= ~(out_mode[i] & ~off[i]);
            end
            CHANNEL_PIN_OUT <= lvl_ff;
        end
    end

    // ****************************************************************
    // Counter control and interrupts
    // ****************************************************************
    // Counter reset is a write-only strobe, never stored
    always_ff @(posedge CLK) begin
        if (RST) begin
            COUNTER_HALT <= `TCMFC_RST_HALT;
            COUNTER_RESET <= 1'b0;
            int_mask_ff <= 6'h00;
            int_stat_ff <= 6'h00;
            CHANNEL_IRQ <= 6'h00;
            IRQ <= 1'b0;
        end else begin
            COUNTER_RESET <= 1'b0;
            if (do_wr && awaddr_ff == `TCMFC_OFS_TSC && wstrb_ff[0]) begin
                COUNTER_HALT <= wdata_ff[`TCMFC_BIT_HALT];
                COUNTER_RESET <= wdata_ff[`TCMFC_BIT_CRST];
            end
            if (do_wr && awaddr_ff == `TCMFC_OFS_INT_MASK && wstrb_ff[0])
                int_mask_ff <= wdata_ff[5:0];
            // Set wins over a same-cycle write-one clear
            if (do_wr && awaddr_ff == `TCMFC_OFS_INT_STAT && wstrb_ff[0])
                int_stat_ff <= (int_stat_ff & ~wdata_ff[5:0]) | ev;
            else
                int_stat_ff <= int_stat_ff | ev;
            CHANNEL_IRQ <= flag_ff & ie_ff & ~off;
            IRQ <= |(int_stat_ff & int_mask_ff);
        end
    end

    // ****************************************************************
    // AXI4-Lite read path
    // ****************************************************************
    assign ar_fire = S_AXI_ARVALID & S_AXI_ARREADY;
    assign rd_st = ch_index(S_AXI_ARADDR, `TCMFC_OFS_STAT_BASE);
    assign rd_cmp = ch_index(S_AXI_ARADDR, `TCMFC_OFS_CMP_BASE);

    // Data captured at address accept, answered next cycle
    always_ff @(posedge CLK) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= `TCMFC_RESP_OKAY;
        end else if (ar_fire) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= `TCMFC_RESP_OKAY;
            S_AXI_RDATA <= 32'h0000_0000;
            if (rd_st != 3'h7) begin
                if (!off[rd_st])
                    S_AXI_RDATA[7:0] <= {flag_ff[rd_st], ie_ff[rd_st], bms_ff[rd_st],
                                         mode_ff[rd_st], els_ff[rd_st], 2'h0};
            end else if (rd_cmp != 3'h7)
                S_AXI_RDATA[15:0] <= cmp_ff[rd_cmp];
            else if (S_AXI_ARADDR == `TCMFC_OFS_TSC)
                S_AXI_RDATA[`TCMFC_BIT_HALT] <= COUNTER_HALT;
            else if (S_AXI_ARADDR == `TCMFC_OFS_INT_STAT)
                S_AXI_RDATA[5:0] <= int_stat_ff;
            else if (S_AXI_ARADDR == `TCMFC_OFS_INT_MASK)
                S_AXI_RDATA[5:0] <= int_mask_ff;
            else
                S_AXI_RRESP <= `TCMFC_RESP_SLVERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end
endmodule : tcmfc_top
`default_nettype wire

// [verification/tcmfc_chk.sv]
// Port-level checker of the timer channel block
`timescale 1ns/1ps
`default_nettype none
module tcmfc_chk (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic S_AXI_RVALID,
    input wire logic [5:0] CHANNEL_PIN_OUT,
    input wire logic [5:0] CHANNEL_PIN_OE_N,
    input wire logic [5:0] CHANNEL_IRQ,
    input wire logic COUNTER_HALT,
    input wire logic COUNTER_RESET,
    input wire logic IRQ
);
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge CLK); endclocking
    // Reset must quiet every request; reset checks run with reset high
    property p_rst_out;
        RST |=> CHANNEL_IRQ == 6'h00 && !IRQ && COUNTER_HALT;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("request or halt wrong after reset");
    property p_rst_pins;
        RST |=> CHANNEL_PIN_OE_N == 6'h3F && CHANNEL_PIN_OUT == 6'h3F;
    endproperty
    a_rst_pins: assert property (p_rst_pins) else $error("pins not released high after reset");
    property p_rd_unmap;
        disable iff (RST) S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR >= 8'h3C
            |=> S_AXI_RVALID && S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0;
    endproperty
    a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not refused");
    property p_wr_unmap;
        disable iff (RST) S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
            && S_AXI_AWADDR >= 8'h3C |-> ##2 S_AXI_BVALID && S_AXI_BRESP == 2'h2;
    endproperty
    a_wr_unmap: assert property (p_wr_unmap) else $error("unmapped write not refused");
    property p_wr_busy;
        disable iff (RST) S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
            |=> !S_AXI_AWREADY && !S_AXI_WREADY ##1 S_AXI_BVALID;
    endproperty
    a_wr_busy: assert property (p_wr_busy) else $error("write answer timing wrong");
    property p_rd_busy;
        disable iff (RST) S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY;
    endproperty
    a_rd_busy: assert property (p_rd_busy) else $error("read answer timing wrong");
    // Status words carry only bits 7:2
    property p_rd_stat;
        disable iff (RST) S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR < 8'h18
            |=> S_AXI_RDATA[31:8] == 24'h0 && S_AXI_RDATA[1:0] == 2'h0;
    endproperty
    a_rd_stat: assert property (p_rd_stat) else $error("status word has stray bits");
    property p_rd_odd;
        disable iff (RST) S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR < 8'h18
            && S_AXI_ARADDR[2] |=> !S_AXI_RDATA[5];
    endproperty
    a_rd_odd: assert property (p_rd_odd) else $error("odd channel shows buffered bit");
    property p_crst;
        disable iff (RST) COUNTER_RESET |=> !COUNTER_RESET;
    endproperty
    a_crst: assert property (p_crst) else $error("counter reset pulse too long");
    c_chirq: cover property (disable iff (RST) $rose(|CHANNEL_IRQ));
    c_irq: cover property (disable iff (RST) $rose(IRQ));
    c_crst: cover property (disable iff (RST) COUNTER_RESET);
endmodule : tcmfc_chk
bind tcmfc_top tcmfc_chk u_chk (.CLK(CLK), .RST(RST), .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .CHANNEL_PIN_OUT(CHANNEL_PIN_OUT), .CHANNEL_PIN_OE_N(CHANNEL_PIN_OE_N),
    .CHANNEL_IRQ(CHANNEL_IRQ), .COUNTER_HALT(COUNTER_HALT), .COUNTER_RESET(COUNTER_RESET),
    .IRQ(IRQ));
`default_nettype wire

// [verification/tcmfc_tb_top.sv]
// Self-checking bench of the timer channel block
`timescale 1ns/1ps
`default_nettype none
module tcmfc_tb_top import tcmfc_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [3:0] ws = 4'hF;
    logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
    logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, halt, crst, irq;
    logic [1:0] b_resp, r_resp;
    logic [31:0] r_data;
    logic [15:0] cnt = 16'h0000;
    logic [5:0] pin_in = 6'h00;
    logic [5:0] pin_out, pin_oe_n, ch_irq;
    int n_fail = 0;
    int checks_done = 0;
    tcmfc_top i_dut (.CLK(clk), .RST(rst), .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_v),
        .S_AXI_AWREADY(aw_rdy), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(w_v),
        .S_AXI_WREADY(w_rdy), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_r),
        .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_rdy),
        .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_r),
        .COUNT(cnt), .CHANNEL_PIN_IN(pin_in), .CHANNEL_PIN_OUT(pin_out),
        .CHANNEL_PIN_OE_N(pin_oe_n), .CHANNEL_IRQ(ch_irq), .COUNTER_HALT(halt),
        .COUNTER_RESET(crst), .IRQ(irq));
    // ****************
    // Helpers
    // ****************
    // 20 MHz clock
    initial forever #25 clk = ~clk;
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit ao = 0;
        bit wo = 0;
        @(posedge clk);
        aw_addr <= a;
        wd <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_r <= 1'b1;
        while (!(ao && wo)) begin
            @(posedge clk);
            if (aw_v && aw_rdy) begin
                ao = 1;
                aw_v <= 1'b0;
            end
            if (w_v && w_rdy) begin
                wo = 1;
                w_v <= 1'b0;
            end
        end
        while (!b_v) @(posedge clk);
        b_r <= 1'b0;
        chk("bresp", 32'(b_resp), 32'(er));
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge clk);
        ar_addr <= a;
        ar_v <= 1'b1;
        r_r <= 1'b1;
        do @(posedge clk); while (!ar_rdy);
        ar_v <= 1'b0;
        while (!r_v) @(posedge clk);
        r_r <= 1'b0;
        chk($sformatf("reg %h", a), r_data, exp);
        chk("rresp", 32'(r_resp), 32'(er));
    endtask : rchk
    // Pin edges pass a synchroniser, so allow a few cycles
    task automatic pin(input logic [5:0] v);
        @(posedge clk);
        pin_in <= v;
        repeat (6) @(posedge clk);
    endtask : pin
    // ****************
    // Scenarios
    // ****************
    task automatic t_reset;
        rchk(8'h00, 32'h0, 2'h0);
        rchk(8'h18, 32'h20, 2'h0);
        chk("halt", 32'(halt), 32'h1);
        chk("pin_out", 32'(pin_out), 32'h3F);
    endtask : t_reset
    // Rising capture on ch0, then the protected clearing sequence
    task automatic t_capture;
        wr(8'h00, 32'h44, 2'h0);
        pin(6'h01);
        rchk(8'h00, 32'hC4, 2'h0);
        chk("ch_irq", 32'(ch_irq), 32'h01);
        wr(8'h00, 32'hC4, 2'h0);
        rchk(8'h00, 32'hC4, 2'h0);
        wr(8'h00, 32'h44, 2'h0);
        rchk(8'h00, 32'h44, 2'h0);
        chk("ch_irq", 32'(ch_irq), 32'h00);
        pin(6'h00);
        pin(6'h01);
        rchk(8'h00, 32'hC4, 2'h0);
        pin(6'h00);
        pin(6'h01);
        wr(8'h00, 32'h44, 2'h0);
        rchk(8'h00, 32'hC4, 2'h0);
        wr(8'h00, 32'h84, 2'h0);
        // Request register follows the enable one cycle later
        @(posedge clk);
        chk("ch_irq", 32'(ch_irq), 32'h00);
        // Falling-edge capture on ch3: a rising edge must not count
        wr(8'h0C, 32'h48, 2'h0);
        pin(6'h09);
        rchk(8'h0C, 32'h48, 2'h0);
        pin(6'h01);
        rchk(8'h0C, 32'hC8, 2'h0);
    endtask : t_capture
    task automatic t_compare;
        wr(8'h28, 32'h10, 2'h0);
        // Halt and reset the counter before touching a mode bit
        wr(8'h18, 32'h30, 2'h0);
        chk("crst", 32'(crst), 32'h1);
        wr(8'h08, 32'h54, 2'h0);
        wr(8'h38, 32'h04, 2'h0);
        chk("oe_n2", 32'(pin_oe_n[2]), 32'h0);
        cnt <= 16'h0010;
        repeat (4) @(posedge clk);
        rchk(8'h08, 32'hD4, 2'h0);
        chk("ch_irq2", 32'(ch_irq[2]), 32'h1);
        chk("irq", 32'(irq), 32'h1);
        wr(8'h1C, 32'h04, 2'h0);
        repeat (3) @(posedge clk);
        chk("irq", 32'(irq), 32'h0);
    endtask : t_compare
    task automatic t_buffer;
        // Odd channel has no buffered bit, so bit 5 must not stick
        wr(8'h04, 32'h74, 2'h0);
        rchk(8'h04, 32'h54, 2'h0);
        @(posedge clk);
        chk("oe_n1", 32'(pin_oe_n[1]), 32'h0);
        wr(8'h00, 32'h20, 2'h0);
        rchk(8'h04, 32'h0, 2'h0);
        rchk(8'h00, 32'h20, 2'h0);
        chk("oe_n1", 32'(pin_oe_n[1]), 32'h1);
    endtask : t_buffer
    task automatic t_level_and_bus;
        wr(8'h10, 32'h10, 2'h0);
        repeat (3) @(posedge clk);
        chk("pin4", 32'(pin_out[4]), 32'h0);
        wr(8'h10, 32'h00, 2'h0);
        repeat (3) @(posedge clk);
        chk("pin4", 32'(pin_out[4]), 32'h1);
        rchk(8'h40, 32'h0, 2'h2);
        wr(8'h40, 32'h1, 2'h2);
        // Release the counter, then halt it again
        wr(8'h18, 32'h10, 2'h0);
        chk("crst", 32'(crst), 32'h1);
        rchk(8'h18, 32'h0, 2'h0);
        chk("halt", 32'(halt), 32'h0);
        chk("crst", 32'(crst), 32'h0);
        wr(8'h18, 32'h30, 2'h0);
        rchk(8'h18, 32'h20, 2'h0);
        chk("halt", 32'(halt), 32'h1);
    endtask : t_level_and_bus
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    // Watchdog, far beyond the few hundred cycles the scenarios need
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_capture();
        t_compare();
        t_buffer();
        t_level_and_bus();
        tally_and_finish();
    end
endmodule : tcmfc_tb_top
`default_nettype wire
